// [lpr_regs.svh]
// Timing counts, field positions and reset values of the LCD refresh timing block
`ifndef LPR_REGS_SVH
`define LPR_REGS_SVH

// Serialiser queue: 16 bits, fetch only while two 3-bit pushes still fit
`define LPR_Q_ROOM 5'ha
`define LPR_POP_NIB 4'h4
`define LPR_POP_BYTE 4'h8
`define LPR_NEED_NIB 5'h4
`define LPR_NEED_BYTE 5'h8

// Data-cycle phases per shifted group
`define LPR_DIR_LAST_PH 2'h1
`define LPR_MUX_LAST_PH 2'h3

// Dither sequence: 15 frames, 4-level uses it modulo 3
`define LPR_DITH_LAST 4'he
`define LPR_DITH_STEPS4 4'h3

// Reset and idle levels, fetch address step
`define LPR_NIB_IDLE 4'h0
`define LPR_POL_RST 1'b0
`define LPR_ADDR_STEP 16'h1

`endif

// [lpr_pkg.sv]
// Types shared by the LCD refresh timing block
package lpr_pkg;

  typedef enum logic [1:0] {
    PANEL_SPLIT4,
    PANEL_NONSPLIT4,
    PANEL_NONSPLIT8
  } lpr_panel_type;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_SHIFT,
    ST_GAP
  } lpr_state_type;

endpackage

// [lpr_pix_if.sv]
// Carrier between the refresh core and the pixel converter
`timescale 1ns/100ps
interface lpr_pix_if;
  logic [7:0] pixel;
  logic color;
  logic grey16;
  logic [3:0] phase;
  logic [2:0] bits;
  logic [1:0] nbits;

  modport conv (input pixel, input color, input grey16, input phase, output bits, output nbits);
  modport core (output pixel, output color, output grey16, output phase, input bits, input nbits);
endinterface

// [lpr_pixel_conv.sv]
// Pixel byte to panel bits, with time-based grey dithering
`timescale 1ns/100ps
`include "lpr_regs.svh"
module lpr_pixel_conv (
  // Pixel in, panel bits out
  lpr_pix_if.conv pix
);

  function automatic logic dith_on(input logic [3:0] level, input logic [3:0] thresh);
    return level > thresh;
  endfunction

  logic [3:0] ph3;

  always_comb begin
    ph3 = pix.phase % `LPR_DITH_STEPS4;
    if (pix.color) begin
      // RGB332: top two bits of each channel, dithered over three frames
      pix.bits = {dith_on({2'h0, pix.pixel[7:6]}, ph3),
                  dith_on({2'h0, pix.pixel[4:3]}, ph3),
                  dith_on({2'h0, pix.pixel[1:0]}, ph3)};
      pix.nbits = 2'h3;
    end else if (pix.grey16) begin
      pix.bits = {dith_on(pix.pixel[3:0], pix.phase), 2'h0};
      pix.nbits = 2'h1;
    end else begin
      pix.bits = {dith_on({2'h0, pix.pixel[1:0]}, ph3), 2'h0};
      pix.nbits = 2'h1;
    end
  end

endmodule // lpr_pixel_conv

// [lpr_refresh_timing.sv]
// Passive LCD refresh timing: pacing, pixel serialising and panel strobes
`timescale 1ns/100ps
`include "lpr_regs.svh"

module lpr_refresh_timing (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Configuration
  input wire logic enable_in,
  input wire lpr_pkg::lpr_panel_type panel_type_in,
  input wire logic color_mode_in,
  input wire logic grey16_in,
  input wire logic polarity_mode_sel_in,
  input wire logic [7:0] polarity_period_count_in,
  input wire logic [4:0] shift_clock_divisor_in,
  input wire logic [8:0] line_width_count_in,
  input wire logic [9:0] line_period_count_in,
  input wire logic [9:0] panel_height_count_in,
  input wire logic [15:0] upper_base_in,
  input wire logic [15:0] lower_base_in,
  // Video buffer read port
  input wire logic [7:0] pix_data_in,
  output logic [15:0] pix_addr_out,
  output logic pix_rd_out,
  // Panel pins
  output logic shift_clock_out,
  output logic line_latch_pulse_out,
  output logic panel_top_sync_out,
  output logic ac_polarity_toggle_out,
  output logic [3:0] pixel_nibble_out,
  output logic panel_power_enable_out,
  output logic shift_idle_flag_out
);

  // Left-aligned queue update: pop from the top, then append below the rest
  function automatic logic [20:0] q_upd(input logic [15:0] q, input logic [4:0] cnt,
                                        input logic [3:0] pop, input logic en,
                                        input logic [2:0] bits, input logic [1:0] n);
    logic [15:0] t;
    logic [15:0] ins;
    logic [4:0] c;
    t = q << pop;
    c = cnt - {1'b0, pop};
    ins = en ? ({bits, 13'h0} >> c) : 16'h0;
    t = t | ins;
    c = c + (en ? {3'h0, n} : 5'h0);
    return {c, t};
  endfunction

  lpr_pix_if pix_if ();

  lpr_pixel_conv u_conv (
    .pix(pix_if.conv)
  );

  lpr_pkg::lpr_state_type st, next_st;
  logic [4:0] baud_cnt, next_baud;
  logic [1:0] ph, next_ph;
  logic [8:0] grp_cnt, next_grp;
  logic [9:0] rate_cnt, next_rate;
  logic [9:0] line_cnt, next_line;
  logic [7:0] pol_cnt, next_pol_cnt;
  logic [3:0] frame_ph, next_frame_ph;
  logic [3:0] ld_hold, next_ld_hold;
  logic next_cp, next_latch, next_top, next_pol;
  logic [3:0] next_nib;
  logic [15:0] uq, next_uq, lq, next_lq;
  logic [4:0] ucnt, next_ucnt, lcnt, next_lcnt;
  logic [15:0] addr_up, next_addr_up, addr_lo, next_addr_lo, next_addr_out;
  logic fetch_lower, next_fetch_lower, rd_pend, next_rd_pend, rd_lower, next_rd_lower;
  logic next_rd, tgt_lo, room;
  logic [3:0] u_pop, l_pop;
  logic mux, split, wide8, have, halt, tick, frame_end, flush;
  logic [1:0] last_ph;

  assign split = panel_type_in == lpr_pkg::PANEL_SPLIT4;
  assign wide8 = panel_type_in == lpr_pkg::PANEL_NONSPLIT8;
  assign mux = split || wide8;
  assign last_ph = mux ? `LPR_MUX_LAST_PH : `LPR_DIR_LAST_PH;

  assign pix_if.pixel = pix_data_in;
  assign pix_if.color = color_mode_in;
  assign pix_if.grey16 = grey16_in;
  assign pix_if.phase = frame_ph;

  // Stall the baud clock rather than shift out stale bits when fetch falls behind
  assign have = (ucnt >= (wide8 ? `LPR_NEED_BYTE : `LPR_NEED_NIB)) &&
                (!split || lcnt >= `LPR_NEED_NIB);
  assign halt = (st == lpr_pkg::ST_SHIFT) && (ph == 2'h0) && !have;
  assign tick = enable_in && (st != lpr_pkg::ST_OFF) && (baud_cnt == 5'h0) && !halt;
  assign flush = frame_end || (st == lpr_pkg::ST_OFF) || !enable_in;

  // Panel timing
  always_comb begin
    next_st = st;
    next_baud = baud_cnt;
    next_ph = ph;
    next_grp = grp_cnt;
    next_rate = rate_cnt;
    next_line = line_cnt;
    next_pol_cnt = pol_cnt;
    next_frame_ph = frame_ph;
    next_ld_hold = ld_hold;
    next_cp = shift_clock_out;
    next_nib = pixel_nibble_out;
    next_latch = 1'b0;
    next_top = panel_top_sync_out;
    next_pol = ac_polarity_toggle_out;
    u_pop = 4'h0;
    l_pop = 4'h0;
    frame_end = 1'b0;
    if (baud_cnt != 5'h0) begin
      next_baud = baud_cnt - 5'h1;
    end else if (!halt) begin
      next_baud = shift_clock_divisor_in;
    end
    if (tick && rate_cnt != 10'h0) begin
      next_rate = rate_cnt - 10'h1;
    end
    case (st)
      lpr_pkg::ST_OFF: begin
        next_st = lpr_pkg::ST_SHIFT;
        next_ph = 2'h0;
        next_grp = line_width_count_in;
        next_rate = line_period_count_in;
        next_line = panel_height_count_in;
        next_pol_cnt = polarity_period_count_in;
      end
      lpr_pkg::ST_SHIFT: begin
        if (tick) begin
          next_ph = ph + 2'h1;
          if (ph == 2'h0) begin
            u_pop = wide8 ? `LPR_POP_BYTE : `LPR_POP_NIB;
            l_pop = split ? `LPR_POP_NIB : 4'h0;
            next_nib = uq[15:12];
            next_ld_hold = split ? lq[15:12] : uq[11:8];
            next_cp = !mux;
          end else if (ph == 2'h1) begin
            // Lower nibble appears as the external latch takes the upper one
            next_cp = mux;
            if (mux) begin
              next_nib = ld_hold;
            end
          end else if (ph == 2'h3) begin
            next_cp = 1'b0;
          end
          if (ph == last_ph) begin
            next_ph = 2'h0;
            if (grp_cnt == 9'h0) begin
              next_st = lpr_pkg::ST_GAP;
            end else begin
              next_grp = grp_cnt - 9'h1;
            end
          end
        end
      end
      lpr_pkg::ST_GAP: begin
        if (tick && rate_cnt == 10'h0) begin
          next_latch = 1'b1;
          next_rate = line_period_count_in;
          next_st = lpr_pkg::ST_SHIFT;
          next_grp = line_width_count_in;
          next_ph = 2'h0;
          next_top = line_cnt == 10'h0;
          if (line_cnt == 10'h0) begin
            frame_end = 1'b1;
            next_line = panel_height_count_in;
            next_frame_ph = (frame_ph == `LPR_DITH_LAST) ? 4'h0 : frame_ph + 4'h1;
            if (!polarity_mode_sel_in) begin
              next_pol = !ac_polarity_toggle_out;
            end
          end else begin
            next_line = line_cnt - 10'h1;
          end
          if (polarity_mode_sel_in) begin
            if (pol_cnt == 8'h0) begin
              next_pol = !ac_polarity_toggle_out;
              next_pol_cnt = polarity_period_count_in;
            end else begin
              next_pol_cnt = pol_cnt - 8'h1;
            end
          end else begin
            next_pol_cnt = polarity_period_count_in;
          end
        end
      end
      default: begin
        next_st = lpr_pkg::ST_OFF;
      end
    endcase
    if (!enable_in) begin
      next_st = lpr_pkg::ST_OFF;
      next_baud = 5'h0;
      next_cp = 1'b0;
      next_nib = `LPR_NIB_IDLE;
      next_latch = 1'b0;
      next_top = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st <= lpr_pkg::ST_OFF;
      baud_cnt <= 5'h0;
      ph <= 2'h0;
      grp_cnt <= 9'h0;
      rate_cnt <= 10'h0;
      line_cnt <= 10'h0;
      pol_cnt <= 8'h0;
      frame_ph <= 4'h0;
      ld_hold <= 4'h0;
      shift_clock_out <= 1'b0;
      pixel_nibble_out <= `LPR_NIB_IDLE;
      line_latch_pulse_out <= 1'b0;
      panel_top_sync_out <= 1'b0;
      ac_polarity_toggle_out <= `LPR_POL_RST;
      panel_power_enable_out <= 1'b0;
      shift_idle_flag_out <= 1'b1;
    end else begin
      st <= next_st;
      baud_cnt <= next_baud;
      ph <= next_ph;
      grp_cnt <= next_grp;
      rate_cnt <= next_rate;
      line_cnt <= next_line;
      pol_cnt <= next_pol_cnt;
      frame_ph <= next_frame_ph;
      ld_hold <= next_ld_hold;
      shift_clock_out <= next_cp;
      pixel_nibble_out <= next_nib;
      line_latch_pulse_out <= next_latch;
      panel_top_sync_out <= next_top;
      ac_polarity_toggle_out <= next_pol;
      panel_power_enable_out <= enable_in;
      shift_idle_flag_out <= next_st != lpr_pkg::ST_SHIFT;
    end
  end

  // Buffer fetch and bit queues
  always_comb begin
    next_addr_up = addr_up;
    next_addr_lo = addr_lo;
    next_addr_out = pix_addr_out;
    next_fetch_lower = fetch_lower;
    next_rd = 1'b0;
    next_rd_pend = 1'b0;
    next_rd_lower = rd_lower;
    {next_ucnt, next_uq} = q_upd(uq, ucnt, u_pop, rd_pend && !rd_lower,
                                 pix_if.bits, pix_if.nbits);
    {next_lcnt, next_lq} = q_upd(lq, lcnt, l_pop, rd_pend && rd_lower,
                                 pix_if.bits, pix_if.nbits);
    tgt_lo = split && fetch_lower;
    room = tgt_lo ? (lcnt <= `LPR_Q_ROOM) : (ucnt <= `LPR_Q_ROOM);
    if (room) begin
      next_rd = 1'b1;
      next_rd_pend = 1'b1;
      next_rd_lower = tgt_lo;
      next_addr_out = tgt_lo ? addr_lo : addr_up;
      if (tgt_lo) begin
        next_addr_lo = addr_lo + `LPR_ADDR_STEP;
      end else begin
        next_addr_up = addr_up + `LPR_ADDR_STEP;
      end
      next_fetch_lower = split && !fetch_lower;
    end
    // Frame end drops leftovers and in-flight reads so each frame starts aligned
    if (flush) begin
      next_uq = 16'h0;
      next_ucnt = 5'h0;
      next_lq = 16'h0;
      next_lcnt = 5'h0;
      next_rd = 1'b0;
      next_rd_pend = 1'b0;
      next_addr_up = upper_base_in;
      next_addr_lo = lower_base_in;
      next_fetch_lower = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      uq <= 16'h0;
      ucnt <= 5'h0;
      lq <= 16'h0;
      lcnt <= 5'h0;
      addr_up <= 16'h0;
      addr_lo <= 16'h0;
      fetch_lower <= 1'b0;
      rd_pend <= 1'b0;
      rd_lower <= 1'b0;
      pix_addr_out <= 16'h0;
      pix_rd_out <= 1'b0;
    end else begin
      uq <= next_uq;
      ucnt <= next_ucnt;
      lq <= next_lq;
      lcnt <= next_lcnt;
      addr_up <= next_addr_up;
      addr_lo <= next_addr_lo;
      fetch_lower <= next_fetch_lower;
      rd_pend <= next_rd_pend;
      rd_lower <= next_rd_lower;
      pix_addr_out <= next_addr_out;
      pix_rd_out <= next_rd;
    end
  end

  // Shift clock rises seen since the last latch
  logic [9:0] cp_seen;
  always_ff @(posedge clock_in) begin
    if (rst_in || st == lpr_pkg::ST_OFF) begin
      cp_seen <= 10'h0;
    end else if (line_latch_pulse_out) begin
      cp_seen <= {9'h0, next_cp && !shift_clock_out};
    end else if (next_cp && !shift_clock_out) begin
      cp_seen <= cp_seen + 10'h1;
    end
  end

  default clocking lpr_cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_latch_pulse;
    line_latch_pulse_out ##1 !line_latch_pulse_out;
  endsequence

  sequence s_frame_edge;
    line_latch_pulse_out && panel_top_sync_out;
  endsequence

  a_latch_from_gap: assert property (
    line_latch_pulse_out |-> $past(st == lpr_pkg::ST_GAP))
    else $error("line latch without a finished line");
  a_latch_single: assert property (
    line_latch_pulse_out |-> s_latch_pulse)
    else $error("line latch wider than one cycle");
  a_nibble_on_rise: assert property (
    panel_power_enable_out && !mux && $changed(pixel_nibble_out) |-> $rose(shift_clock_out))
    else $error("nibble changed away from shift clock rise");
  a_idle_no_clock: assert property (
    shift_idle_flag_out |-> !shift_clock_out)
    else $error("shift clock high while idle flag set");
  a_top_on_latch: assert property (
    $past(enable_in) && $changed(panel_top_sync_out) |-> line_latch_pulse_out)
    else $error("top sync moved without a line latch");
  a_pol_frame: assert property (
    $past(enable_in) && !$past(polarity_mode_sel_in) && $changed(ac_polarity_toggle_out)
    |-> s_frame_edge)
    else $error("frame polarity flip off the frame edge");
  a_pol_on_latch: assert property (
    $changed(ac_polarity_toggle_out) |-> line_latch_pulse_out)
    else $error("polarity flipped without a line latch");
  a_power_off: assert property (
    !enable_in |=> !panel_power_enable_out && !shift_clock_out && !line_latch_pulse_out
                   && !panel_top_sync_out && pixel_nibble_out == `LPR_NIB_IDLE)
    else $error("panel strobes active while disabled");
  a_line_width: assert property (
    line_latch_pulse_out |-> cp_seen == {1'b0, line_width_count_in} + 10'h1)
    else $error("shift clock count per line wrong");

endmodule // lpr_refresh_timing

// [lpr_panel_model.sv]
// Behavioural passive panel with the external upper-nibble register
`timescale 1ns/100ps
module lpr_panel_model (
  // Sampling clock
  input wire logic clock_in,
  // Bench setup
  input wire logic mux_in,
  input wire logic [8:0] exp_groups_in,
  // Panel pins
  input wire logic shift_clock_in,
  input wire logic [3:0] nibble_in,
  input wire logic latch_in,
  input wire logic top_sync_in,
  input wire logic polarity_in,
  input wire logic power_in,
  input wire logic idle_in,
  // Observations
  output logic [15:0] err_count_out,
  output logic [7:0] frame_first_out,
  output logic [7:0] flip_gap_out
);
  logic prev_sck;
  logic prev_pol;
  logic prev_idle;
  logic [3:0] prev_nib;
  logic [3:0] upper_reg;
  logic [8:0] groups;
  logic [7:0] since_flip;

  initial begin
    err_count_out = 16'h0;
    frame_first_out = 8'h0;
    flip_gap_out = 8'h0;
    prev_sck = 1'b0;
    prev_pol = 1'b0;
    prev_idle = 1'b1;
    prev_nib = 4'h0;
    upper_reg = 4'h0;
    groups = 9'h0;
    since_flip = 8'h0;
  end

  // Pins sampled on the system clock, so edges of the panel clock never race
  always @(posedge clock_in) begin
    prev_sck <= shift_clock_in;
    prev_nib <= nibble_in;
    prev_pol <= polarity_in;
    prev_idle <= idle_in;
    if (!prev_sck && shift_clock_in) begin
      upper_reg <= prev_nib;
    end
    if (prev_sck && shift_clock_in && nibble_in !== prev_nib) begin
      err_count_out = err_count_out + 16'h1;
    end
    if (shift_clock_in && idle_in) begin
      err_count_out = err_count_out + 16'h1;
    end
    if (prev_sck && !shift_clock_in) begin
      if (groups == 9'h0 && top_sync_in) begin
        frame_first_out <= mux_in ? {upper_reg, prev_nib} : {4'h0, prev_nib};
      end
      groups <= groups + 9'h1;
    end
    // Idle flag drops with the latch itself, so look at the cycle before it
    if (latch_in) begin
      if (groups !== exp_groups_in || !prev_idle) begin
        err_count_out = err_count_out + 16'h1;
      end
      groups <= 9'h0;
    end
    if (!power_in) begin
      groups <= 9'h0;
    end
    if (polarity_in !== prev_pol) begin
      flip_gap_out <= since_flip + {7'h0, latch_in};
      since_flip <= 8'h0;
    end else if (latch_in) begin
      since_flip <= since_flip + 8'h1;
    end
  end
endmodule // lpr_panel_model

// [lpr_refresh_timing_tb_top.sv]
// Self-checking bench for the LCD refresh timing block
`timescale 1ns/100ps
module lpr_refresh_timing_tb_top;
  logic clock_in, rst_in, enable_in, color_mode_in, grey16_in, polarity_mode_sel_in;
  lpr_pkg::lpr_panel_type panel_type_in;
  logic [4:0] shift_clock_divisor_in;
  logic [8:0] line_width_count_in, exp_groups;
  logic [7:0] pix_data_in, frame_first, flip_gap;
  logic [15:0] pix_addr_out, model_err;
  logic pix_rd_out, shift_clock_out, line_latch_pulse_out, panel_top_sync_out;
  logic ac_polarity_toggle_out, panel_power_enable_out, shift_idle_flag_out;
  logic [3:0] pixel_nibble_out;
  int bad_count = 0;
  int check_count = 0;
  // Mode table: type, colour, grey16, polarity mode, divisor, width, first group
  lpr_pkg::lpr_panel_type types [5] = '{lpr_pkg::PANEL_SPLIT4, lpr_pkg::PANEL_NONSPLIT4,
    lpr_pkg::PANEL_NONSPLIT8, lpr_pkg::PANEL_NONSPLIT4, lpr_pkg::PANEL_NONSPLIT4};
  logic colors [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic greys [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic pmodes [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [4:0] divs [5] = '{5'h7, 5'h7, 5'h9, 5'h7, 5'h8};
  logic [8:0] widths [5] = '{9'h3, 9'h2, 9'h3, 9'h1, 9'h3};
  logic [7:0] firsts [5] = '{8'ha5, 8'h0a, 8'haa, 8'h0e, 8'h0a};

  lpr_refresh_timing dut (
    .clock_in(clock_in), .rst_in(rst_in), .enable_in(enable_in),
    .panel_type_in(panel_type_in), .color_mode_in(color_mode_in), .grey16_in(grey16_in),
    .polarity_mode_sel_in(polarity_mode_sel_in), .polarity_period_count_in(8'h01),
    .shift_clock_divisor_in(shift_clock_divisor_in), .line_width_count_in(line_width_count_in),
    .line_period_count_in(10'h014), .panel_height_count_in(10'h002),
    .upper_base_in(16'h0100), .lower_base_in(16'h0201), .pix_data_in(pix_data_in),
    .pix_addr_out(pix_addr_out), .pix_rd_out(pix_rd_out), .shift_clock_out(shift_clock_out),
    .line_latch_pulse_out(line_latch_pulse_out), .panel_top_sync_out(panel_top_sync_out),
    .ac_polarity_toggle_out(ac_polarity_toggle_out), .pixel_nibble_out(pixel_nibble_out),
    .panel_power_enable_out(panel_power_enable_out), .shift_idle_flag_out(shift_idle_flag_out));

  lpr_panel_model panel (
    .clock_in(clock_in), .mux_in(panel_type_in != lpr_pkg::PANEL_NONSPLIT4),
    .exp_groups_in(exp_groups), .shift_clock_in(shift_clock_out),
    .nibble_in(pixel_nibble_out), .latch_in(line_latch_pulse_out),
    .top_sync_in(panel_top_sync_out), .polarity_in(ac_polarity_toggle_out),
    .power_in(panel_power_enable_out), .idle_in(shift_idle_flag_out),
    .err_count_out(model_err), .frame_first_out(frame_first), .flip_gap_out(flip_gap));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // Video buffer: even bytes all ones, odd bytes all zeros
  // Answers inside the strobe cycle, since the core takes the byte at the next edge
  always @(negedge clock_in) begin
    if (pix_rd_out === 1'b1) begin
      pix_data_in <= pix_addr_out[0] ? 8'h00 : 8'hff;
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    begin
      check_count++;
      if (got !== exp) begin
        bad_count++;
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  task automatic end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  // Counts latches up to and including the next rise of top sync
  task automatic frame_span(output logic [15:0] n);
    logic prev;
    begin
      n = 16'h0;
      prev = 1'b1;
      // No limit of its own: a lost frame sync runs into the watchdog
      forever begin
        @(posedge clock_in);
        #1;
        if (line_latch_pulse_out === 1'b1) n = n + 16'h1;
        if (prev === 1'b0 && panel_top_sync_out === 1'b1) break;
        prev = panel_top_sync_out;
      end
    end
  endtask

  task automatic wait_latch(output logic [15:0] g);
    begin
      g = 16'h0;
      forever begin
        @(posedge clock_in);
        #1;
        g = g + 16'h1;
        if (line_latch_pulse_out === 1'b1) break;
      end
    end
  endtask

  task automatic run_mode(input int i);
    logic [15:0] n;
    logic [15:0] pins;
    logic [15:0] e;
    logic [15:0] g;
    begin
      @(posedge clock_in);
      enable_in <= 1'b0;
      panel_type_in <= types[i];
      color_mode_in <= colors[i];
      grey16_in <= greys[i];
      polarity_mode_sel_in <= pmodes[i];
      shift_clock_divisor_in <= divs[i];
      line_width_count_in <= widths[i];
      exp_groups <= widths[i] + 9'h1;
      repeat (2) @(posedge clock_in);
      #1;
      pins = {8'h0, shift_clock_out, line_latch_pulse_out, panel_top_sync_out,
              panel_power_enable_out, pixel_nibble_out};
      check("disabled pins", 16'h0, pins);
      @(posedge clock_in);
      enable_in <= 1'b1;
      @(posedge clock_in);
      #1;
      check("power on", 16'h1, {15'h0, panel_power_enable_out});
      frame_span(n);
      frame_span(n);
      check("lines per frame", 16'h3, n);
      wait_latch(n);
      wait_latch(n);
      e = 16'h15 * ({11'h0, divs[i]} + 16'h1);
      check("latch spacing", e, n);
      e = {8'h0, firsts[i]};
      g = {8'h0, frame_first};
      check("first hi", e & 16'hf0, g & 16'hf0);
      check("first lo", e & 16'hf, g & 16'hf);
      check("polarity gap", pmodes[i] ? 16'h2 : 16'h3, {8'h0, flip_gap});
    end
  endtask

  initial begin
    repeat (40000) @(posedge clock_in);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_in = 1'b1;
    enable_in = 1'b0;
    panel_type_in = lpr_pkg::PANEL_NONSPLIT4;
    color_mode_in = 1'b0;
    grey16_in = 1'b1;
    polarity_mode_sel_in = 1'b0;
    shift_clock_divisor_in = 5'h7;
    line_width_count_in = 9'h3;
    exp_groups = 9'h4;
    pix_data_in = 8'h00;
    repeat (20) @(posedge clock_in);
    #1;
    check("reset levels", 16'h4, {13'h0, shift_idle_flag_out, ac_polarity_toggle_out,
      panel_power_enable_out});
    @(posedge clock_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      run_mode(i);
    end
    check("panel protocol", 16'h0, model_err);
    end_of_test();
  end
endmodule // lpr_refresh_timing_tb_top
